/* design/pfs_port_efg.sv */
// Behaviour
// - three 16-bit read/write mode registers, pin n field at bits 2n+1 and 2n.
// - code 00 alternate, 01 output, 10 input with pull-up, 11 input plain.
// - port E resets to aaaa with strap high, 2aa8 with strap low.
// - mode registers load only at power-on reset, not manual reset.
// - port E pins 0 and 7 have no function at 00; reset 00 emu, 10 normal.
// - port E 00 is alternate on pins 2,4,5, reserved on 1,3,6.
// - port F resets aaaa normal, 00aa emu; code 01 reserved on all pins.
// - port G resets aaaa normal, a200 emu; code 01 reserved on all pins.
// - port G pins 4,6,7 select alternate at 00 and reset to 10.
// - port G pin 6 is the strap during reset, plain input after.
// - port G pin 0 decodes bit 3 with bit 0; bit 1 unused.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
module pfs_port_efg (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic MANUAL_RESET,
  input wire logic [pfs_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [pfs_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [pfs_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EMULATION_STRAP_PIN,
  output logic PORT_G_BIT6_INPUT,
  output logic EMULATION_MODE,
  output pfs_pkg::pfs_port_ctrl_s PORT_E_CTRL,
  output pfs_pkg::pfs_port_ctrl_s PORT_F_CTRL,
  output pfs_pkg::pfs_port_ctrl_s PORT_G_CTRL
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [pfs_pkg::REG_W-1:0] merge16(
    input logic [pfs_pkg::REG_W-1:0] old_val,
    input logic [pfs_pkg::REG_W-1:0] new_val,
    input logic [1:0] be
  );
    logic [pfs_pkg::REG_W-1:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (be[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [pfs_pkg::REG_W-1:0] port_e_pin_mode_ff;
  logic [pfs_pkg::REG_W-1:0] port_f_pin_mode_ff;
  logic [pfs_pkg::REG_W-1:0] port_g_pin_mode_ff;
  logic [pfs_pkg::REG_W-1:0] nxt_port_e_pin_mode;
  logic [pfs_pkg::REG_W-1:0] nxt_port_f_pin_mode;
  logic [pfs_pkg::REG_W-1:0] nxt_port_g_pin_mode;
  pfs_pkg::pfs_bus_e bus_state_ff;
  pfs_pkg::pfs_bus_e nxt_bus_state;
  logic waitrequest_ff;
  logic nxt_waitrequest;
  logic [pfs_pkg::DATA_W-1:0] readdata_ff;
  logic [pfs_pkg::DATA_W-1:0] nxt_readdata;
  pfs_pkg::pfs_port_ctrl_s port_e_ctrl_ff;
  pfs_pkg::pfs_port_ctrl_s port_f_ctrl_ff;
  pfs_pkg::pfs_port_ctrl_s port_g_ctrl_ff;
  pfs_pkg::pfs_port_ctrl_s nxt_port_e_ctrl;
  pfs_pkg::pfs_port_ctrl_s nxt_port_f_ctrl;
  pfs_pkg::pfs_port_ctrl_s nxt_port_g_ctrl;
  logic emulation_ff;
  logic bit6_input_ff;

  ////////////////////////////////////////////////////////////////////////////
  // strap catch and pin 6 hand-over
  pfs_strap_capture u_strap (
    .clock(CLOCK),
    .reset(RESET),
    .strap_pin(EMULATION_STRAP_PIN),
    .emulation_ff(emulation_ff),
    .bit6_input_ff(bit6_input_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req = AVS_READ | AVS_WRITE;
  wire hit_e = AVS_ADDRESS == pfs_pkg::OFS_PORT_E;
  wire hit_f = AVS_ADDRESS == pfs_pkg::OFS_PORT_F;
  wire hit_g = AVS_ADDRESS == pfs_pkg::OFS_PORT_G;
  wire hit_status = AVS_ADDRESS == pfs_pkg::OFS_STATUS;
  wire in_idle = bus_state_ff == pfs_pkg::PFS_BUS_IDLE;
  wire in_ack = bus_state_ff == pfs_pkg::PFS_BUS_ACK;
  // write lands at the edge where waitrequest is seen low
  wire commit_wr = in_ack & AVS_WRITE;
  wire [pfs_pkg::REG_W-1:0] wdata16 = AVS_WRITEDATA[pfs_pkg::REG_W-1:0];
  wire [1:0] be16 = AVS_BYTEENABLE[1:0];
  wire [pfs_pkg::DATA_W-1:0] status_word =
    {{(pfs_pkg::DATA_W-1){1'b0}}, emulation_ff};
  wire [pfs_pkg::DATA_W-1:0] rd_mux =
    hit_e ? {16'h0000, port_e_pin_mode_ff} :
    hit_f ? {16'h0000, port_f_pin_mode_ff} :
    hit_g ? {16'h0000, port_g_pin_mode_ff} :
    hit_status ? status_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // register next values, byte-lane merge
  assign nxt_port_e_pin_mode = (commit_wr & hit_e) ?
    merge16(port_e_pin_mode_ff, wdata16, be16) : port_e_pin_mode_ff;
  assign nxt_port_f_pin_mode = (commit_wr & hit_f) ?
    merge16(port_f_pin_mode_ff, wdata16, be16) : port_f_pin_mode_ff;
  assign nxt_port_g_pin_mode = (commit_wr & hit_g) ?
    merge16(port_g_pin_mode_ff, wdata16, be16) : port_g_pin_mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // handshake: one wait cycle, then answer
  always_comb begin
    nxt_bus_state = bus_state_ff;
    nxt_waitrequest = waitrequest_ff;
    nxt_readdata = readdata_ff;
    case (bus_state_ff)
      pfs_pkg::PFS_BUS_IDLE: begin
        if (req) begin
          nxt_bus_state = pfs_pkg::PFS_BUS_ACK;
          nxt_waitrequest = 1'b0;
          nxt_readdata = AVS_READ ? rd_mux : 32'h00000000;
        end
      end
      pfs_pkg::PFS_BUS_ACK: begin
        nxt_bus_state = pfs_pkg::PFS_BUS_IDLE;
        nxt_waitrequest = 1'b1;
      end
      default: begin
        nxt_bus_state = pfs_pkg::PFS_BUS_IDLE;
        nxt_waitrequest = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode registers: power-on reset only, value picked by the strap
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      port_e_pin_mode_ff <= EMULATION_STRAP_PIN ? pfs_pkg::E_RST_NORMAL : pfs_pkg::E_RST_EMU;
      port_f_pin_mode_ff <= EMULATION_STRAP_PIN ? pfs_pkg::F_RST_NORMAL : pfs_pkg::F_RST_EMU;
      port_g_pin_mode_ff <= EMULATION_STRAP_PIN ? pfs_pkg::G_RST_NORMAL : pfs_pkg::G_RST_EMU;
    end else begin
      port_e_pin_mode_ff <= nxt_port_e_pin_mode;
      port_f_pin_mode_ff <= nxt_port_f_pin_mode;
      port_g_pin_mode_ff <= nxt_port_g_pin_mode;
    end
  end

  // bus side also returns to idle on manual reset
  always_ff @(posedge CLOCK) begin
    if (RESET | MANUAL_RESET) begin
      bus_state_ff <= pfs_pkg::PFS_BUS_IDLE;
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else begin
      bus_state_ff <= nxt_bus_state;
      waitrequest_ff <= nxt_waitrequest;
      readdata_ff <= nxt_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin decode of the mode fields
  genvar i;
  generate
    for (i = 0; i < pfs_pkg::PINS; i++) begin : g_pin
      pfs_pkg::pfs_pin_ctrl_s e_pin;
      pfs_pkg::pfs_pin_ctrl_s f_pin;
      pfs_pkg::pfs_pin_ctrl_s g_pin;
      wire [1:0] e_code = port_e_pin_mode_ff[2*i+1:2*i];
      wire [1:0] f_code = port_f_pin_mode_ff[2*i+1:2*i];
      wire [1:0] g_code = (i == 0) ?
        {port_g_pin_mode_ff[pfs_pkg::G_PIN0_HIGH_BIT], port_g_pin_mode_ff[pfs_pkg::G_PIN0_LOW_BIT]} :
        port_g_pin_mode_ff[2*i+1:2*i];

      pfs_field_decode #(
        .ALT_OK(pfs_pkg::E_ALT_OK[i]),
        .OUT_OK(pfs_pkg::E_OUT_OK[i])
      ) u_e (
        .code(e_code),
        .ctrl(e_pin)
      );

      pfs_field_decode #(
        .ALT_OK(pfs_pkg::F_ALT_OK[i]),
        .OUT_OK(pfs_pkg::F_OUT_OK[i])
      ) u_f (
        .code(f_code),
        .ctrl(f_pin)
      );

      pfs_field_decode #(
        .ALT_OK(pfs_pkg::G_ALT_OK[i]),
        .OUT_OK(pfs_pkg::G_OUT_OK[i])
      ) u_g (
        .code(g_code),
        .ctrl(g_pin)
      );

      assign nxt_port_e_ctrl.alt_sel[i] = e_pin.alt_sel;
      assign nxt_port_e_ctrl.out_en[i] = e_pin.out_en;
      assign nxt_port_e_ctrl.pull_up[i] = e_pin.pull_up;
      assign nxt_port_e_ctrl.in_en[i] = e_pin.in_en;
      assign nxt_port_f_ctrl.alt_sel[i] = f_pin.alt_sel;
      assign nxt_port_f_ctrl.out_en[i] = f_pin.out_en;
      assign nxt_port_f_ctrl.pull_up[i] = f_pin.pull_up;
      assign nxt_port_f_ctrl.in_en[i] = f_pin.in_en;
      assign nxt_port_g_ctrl.alt_sel[i] = g_pin.alt_sel;
      assign nxt_port_g_ctrl.out_en[i] = g_pin.out_en;
      assign nxt_port_g_ctrl.pull_up[i] = g_pin.pull_up;
      assign nxt_port_g_ctrl.in_en[i] = g_pin.in_en;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registered pin controls; all released while in reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      port_e_ctrl_ff <= '0;
      port_f_ctrl_ff <= '0;
      port_g_ctrl_ff <= '0;
    end else begin
      port_e_ctrl_ff <= nxt_port_e_ctrl;
      port_f_ctrl_ff <= nxt_port_f_ctrl;
      port_g_ctrl_ff <= nxt_port_g_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign AVS_READDATA = readdata_ff;
  assign AVS_WAITREQUEST = waitrequest_ff;
  assign PORT_G_BIT6_INPUT = bit6_input_ff;
  assign EMULATION_MODE = emulation_ff;
  assign PORT_E_CTRL = port_e_ctrl_ff;
  assign PORT_F_CTRL = port_f_ctrl_ff;
  assign PORT_G_CTRL = port_g_ctrl_ff;

endmodule

/* design/pfs_pkg.sv */
package pfs_pkg;
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int PINS = 8;
  localparam int FIELD_W = 2;
  localparam logic [ADDR_W-1:0] OFS_PORT_E = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PORT_F = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PORT_G = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
  localparam int STATUS_EMU_BIT = 0;
  localparam logic [REG_W-1:0] E_RST_NORMAL = 16'haaaa;
  localparam logic [REG_W-1:0] E_RST_EMU = 16'h2aa8;
  localparam logic [REG_W-1:0] F_RST_NORMAL = 16'haaaa;
  localparam logic [REG_W-1:0] F_RST_EMU = 16'h00aa;
  localparam logic [REG_W-1:0] G_RST_NORMAL = 16'haaaa;
  localparam logic [REG_W-1:0] G_RST_EMU = 16'ha200;
  localparam logic [PINS-1:0] E_ALT_OK = 8'h34;
  localparam logic [PINS-1:0] E_OUT_OK = 8'hff;
  localparam logic [PINS-1:0] F_ALT_OK = 8'hff;
  localparam logic [PINS-1:0] F_OUT_OK = 8'h00;
  localparam logic [PINS-1:0] G_ALT_OK = 8'hff;
  localparam logic [PINS-1:0] G_OUT_OK = 8'h00;
  localparam int G_PIN0_HIGH_BIT = 3;
  localparam int G_PIN0_LOW_BIT = 0;

  typedef enum logic [1:0] {
    PFS_MODE_ALT = 2'h0,
    PFS_MODE_OUT = 2'h1,
    PFS_MODE_IN_PU = 2'h2,
    PFS_MODE_IN = 2'h3
  } pfs_mode_e;

  typedef enum logic [1:0] {
    PFS_BUS_IDLE = 2'h1,
    PFS_BUS_ACK = 2'h2
  } pfs_bus_e;

  typedef struct packed {
    logic alt_sel;
    logic out_en;
    logic pull_up;
    logic in_en;
  } pfs_pin_ctrl_s;

  typedef struct packed {
    logic [PINS-1:0] alt_sel;
    logic [PINS-1:0] out_en;
    logic [PINS-1:0] pull_up;
    logic [PINS-1:0] in_en;
  } pfs_port_ctrl_s;
endpackage

/* design/pfs_field_decode.sv */
module pfs_field_decode #(
  parameter bit ALT_OK = 1'b1,
  parameter bit OUT_OK = 1'b1
) (
  input wire logic [1:0] code,
  output pfs_pkg::pfs_pin_ctrl_s ctrl
);
  // reserved codes leave the pin undriven, no pull-up
  always_comb begin
    ctrl = '0;
    case (pfs_pkg::pfs_mode_e'(code))
      pfs_pkg::PFS_MODE_ALT: begin
        ctrl.alt_sel = ALT_OK;
      end
      pfs_pkg::PFS_MODE_OUT: begin
        ctrl.out_en = OUT_OK;
      end
      pfs_pkg::PFS_MODE_IN_PU: begin
        ctrl.in_en = 1'b1;
        ctrl.pull_up = 1'b1;
      end
      pfs_pkg::PFS_MODE_IN: begin
        ctrl.in_en = 1'b1;
      end
      default: begin
        ctrl = '0;
      end
    endcase
  end
endmodule

/* design/pfs_strap_capture.sv */
module pfs_strap_capture (
  input wire logic clock,
  input wire logic reset,
  input wire logic strap_pin,
  output logic emulation_ff,
  output logic bit6_input_ff
);
  // pin is the strap while reset is high, a plain input afterwards
  always_ff @(posedge clock) begin
    if (reset) begin
      emulation_ff <= ~strap_pin;
      bit6_input_ff <= 1'b0;
    end else begin
      bit6_input_ff <= strap_pin;
    end
  end
endmodule

/* test/pfs_pad_model.sv */
module pfs_pad_model (
  input wire logic reset,
  input wire logic emulation,
  input wire logic run_val,
  output logic pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // strap level while reset holds, plain pin data after release
  assign pad = reset ? !emulation : run_val;
endmodule

/* test/pfs_port_efg_checker.sv */
module pfs_port_efg_checker (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic MANUAL_RESET,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [pfs_pkg::DATA_W-1:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic EMULATION_STRAP_PIN,
  input wire logic EMULATION_MODE,
  input wire pfs_pkg::pfs_port_ctrl_s PORT_E_CTRL,
  input wire pfs_pkg::pfs_port_ctrl_s PORT_F_CTRL,
  input wire pfs_pkg::pfs_port_ctrl_s PORT_G_CTRL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_wait_one_cycle: assert property (disable iff (RESET || MANUAL_RESET)
    AVS_WAITREQUEST && (AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bad wait");
  a_upper_zero: assert property (AVS_READDATA[31:16] == 16'h0000) else $error("upper data set");
  a_f_no_output: assert property (PORT_F_CTRL.out_en == 8'h00) else $error("port f drives");
  a_g_no_output: assert property (PORT_G_CTRL.out_en == 8'h00) else $error("port g drives");
  a_e_alt_pins: assert property ((PORT_E_CTRL.alt_sel & 8'hcb) == 8'h00) else $error("e alt pin");
  a_pull_needs_input: assert property (((PORT_E_CTRL.pull_up & ~PORT_E_CTRL.in_en)
    | (PORT_E_CTRL.out_en & PORT_E_CTRL.in_en)) == 8'h00) else $error("e decode mix");
  a_strap_capture: assert property ($fell(RESET) |-> EMULATION_MODE == !$past(EMULATION_STRAP_PIN))
    else $error("strap not taken");
  a_reset_values: assert property ($fell(RESET) |=> {PORT_E_CTRL, PORT_F_CTRL, PORT_G_CTRL} ==
    (EMULATION_MODE ? {32'h00007e7e, 32'hf0000f0f, 32'h2f00d0d0} : {3{32'h0000ffff}})) else $error("reset decode");
  a_manual_keeps: assert property (MANUAL_RESET |=> $stable(PORT_E_CTRL) && $stable(PORT_F_CTRL) && $stable(PORT_G_CTRL))
    else $error("manual reset hit");
endmodule

/* test/pfs_port_efg_tb.sv */
module pfs_port_efg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, manual_reset, rd, wr, emu, run_val, pad, waitreq, bit6, emu_mode;
  logic [3:0] addr, be, b;
  logic [31:0] wdata, rdata;
  logic [15:0] v, shadow;
  pfs_pkg::pfs_port_ctrl_s e_ctrl, f_ctrl, g_ctrl;
  logic [31:0] expq[$];
  logic [31:0] ectl [4] = '{32'h34000000, 32'h00ff0000, 32'h0000ffff, 32'h000000ff};
  logic [31:0] fgctl [4] = '{32'hff000000, 32'h00000000, 32'h0000ffff, 32'h000000ff};
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h56b0;
  pfs_port_efg i_pfs_port_efg (.CLOCK(clock), .RESET(reset), .MANUAL_RESET(manual_reset), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .EMULATION_STRAP_PIN(pad), .PORT_G_BIT6_INPUT(bit6), .EMULATION_MODE(emu_mode),
    .PORT_E_CTRL(e_ctrl), .PORT_F_CTRL(f_ctrl), .PORT_G_CTRL(g_ctrl));
  pfs_pad_model i_pfs_pad_model (.reset(reset), .emulation(emu), .run_val(run_val), .pad(pad));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] e,
                     input logic [15:0] exp);
    int t;
    t = 0;
    @(posedge clock);
    rd <= !w; wr <= w; addr <= a; wdata <= {16'h0000, d}; be <= e;
    if (!w) expq.push_back({16'h0000, exp});
    do begin
      @(posedge clock);
      t++;
    end while (waitreq !== 1'b0 && t < 50);
    if (t >= 50) begin
      n_fail++;
      $display("mismatch t=%0t bus wait timed out", $time);
      stop_test;
    end
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic settle;
    @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input logic e);
    @(posedge clock);
    emu <= e; reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    settle;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (rd && waitreq === 1'b0) begin
    if (expq.size() == 0) begin
      n_fail++;
      $display("mismatch t=%0t read with no expectation", $time);
    end else begin
      cmp(rdata, expq.pop_front());
    end
  end
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
  initial begin
    reset = 1; manual_reset = 0; rd = 0; wr = 0; addr = 0; wdata = 0; be = 0; emu = 1; run_val = 0;
    do_reset(1'b1);
    cmp(e_ctrl, 32'h00007e7e);
    cmp(f_ctrl, 32'hf0000f0f);
    cmp(g_ctrl, 32'h2f00d0d0);
    bus(0, 4'h0, 0, 4'h3, 16'h2aa8);
    bus(0, 4'h4, 0, 4'h3, 16'h00aa);
    bus(0, 4'h8, 0, 4'h3, 16'ha200);
    bus(0, 4'hc, 0, 4'h3, 16'h0001);
    $display("test emulation reset done");
    for (int c = 0; c < 4; c++) begin
      v = {8{c[1:0]}};
      bus(1, 4'h0, v, 4'h3, 0);
      bus(1, 4'h4, v, 4'h3, 0);
      bus(1, 4'h8, v, 4'h3, 0);
      settle;
      cmp(e_ctrl, ectl[c]);
      cmp(f_ctrl, fgctl[c]);
      cmp(g_ctrl, fgctl[c]);
    end
    bus(1, 4'h8, 16'h0008, 4'h3, 0);
    settle;
    cmp(g_ctrl, 32'hfc000303);
    bus(1, 4'h8, 16'h0002, 4'h3, 0);
    settle;
    cmp(g_ctrl, 32'hff000000);
    $display("test decode done");
    shadow = 16'hffff;
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      b = $random(seed);
      bus(1, 4'h0, v, b, 0);
      if (b[0]) shadow[7:0] = v[7:0];
      if (b[1]) shadow[15:8] = v[15:8];
      bus(0, 4'h0, 0, 4'h3, shadow);
    end
    bus(0, 4'h2, 0, 4'h3, 16'h0000);
    bus(1, 4'hc, 16'h0000, 4'h3, 0);
    bus(0, 4'hc, 0, 4'h3, 16'h0001);
    $display("test byte enables done");
    bus(1, 4'h0, 16'h1234, 4'h3, 0);
    settle;
    @(posedge clock);
    manual_reset <= 1'b1;
    @(posedge clock);
    manual_reset <= 1'b0;
    bus(0, 4'h0, 0, 4'h3, 16'h1234);
    $display("test manual reset done");
    do_reset(1'b0);
    cmp(e_ctrl, 32'h0000ffff);
    cmp(f_ctrl, 32'h0000ffff);
    cmp(g_ctrl, 32'h0000ffff);
    cmp({31'h0, emu_mode}, 32'h0);
    for (int k = 0; k < 3; k++) begin
      bus(0, 4'(4 * k), 0, 4'h3, 16'haaaa);
    end
    @(posedge clock);
    run_val <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    cmp({31'h0, bit6}, 32'h1);
    @(posedge clock);
    run_val <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    cmp({31'h0, bit6}, 32'h0);
    $display("test normal reset done");
    stop_test;
  end
endmodule
bind pfs_port_efg pfs_port_efg_checker i_pfs_port_efg_checker (.CLOCK(CLOCK), .RESET(RESET),
  .MANUAL_RESET(MANUAL_RESET), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .EMULATION_STRAP_PIN(EMULATION_STRAP_PIN), .EMULATION_MODE(EMULATION_MODE),
  .PORT_E_CTRL(PORT_E_CTRL), .PORT_F_CTRL(PORT_F_CTRL), .PORT_G_CTRL(PORT_G_CTRL));
